// [logic/edge_prescaler.sv]
// Programmable 1/2/4/8 event prescaler with clear
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module edge_prescaler
   import timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic src_pulse,
   input wire logic clear,
   input wire prescale_e ratio,
   output logic out_pulse,
   output logic [`TMR_PRESC_W-1:0] phase
);
   logic [`TMR_PRESC_W-1:0] term;

   always_comb begin
      case (ratio)
         PS_DIV1: term = 3'h0;
         PS_DIV2: term = 3'h1;
         PS_DIV4: term = 3'h3;
         PS_DIV8: term = 3'h7;
         default: term = 3'h0;
      endcase
   end

   assign out_pulse = src_pulse && (phase >= term) && !clear;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 3'h0;
      end else if (clear) begin
         phase <= 3'h0;
      end else if (src_pulse) begin
         if (phase >= term) begin
            phase <= 3'h0;
         end else begin
            phase <= phase + 3'h1;
         end
      end
   end
endmodule // edge_prescaler
`default_nettype wire

// [logic/pin_sync.sv]
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // pin_sync
`default_nettype wire

// [logic/timer_counter.sv]
// Sixteen-bit timer counter with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
// Behaviour
// - 16-bit count in two RW bytes, counts up and wraps FFFFh to 0000h
// - Wrap latches overflow flag; request only while overflow enable is set
// - Control bit 1 picks internal clock (0) or external pin (1)
// - Internal source advances once per instruction cycle after prescaler
// - Internal source ignores the sync control bit
// - External: oscillator pin if osc enable set, else count pin
// - Control bit 0 runs the counter when one, stops it when zero
// - Control bits 5:4 select prescale 1:1, 1:2, 1:4, 1:8
// - Sync bit clear: prescaler output synchronised, prescaler ahead of it
// - Synchronised external mode does not advance in sleep; prescaler runs
// - Sync bit set: counts through sleep, enabled overflow wakes core
// - Asynchronous mode need not serve as compare or capture time base
// - Reads of either count byte return a valid value
// - Control bit 3 enables oscillator; both its pins become inputs
// - Special event trigger from either compare unit clears the counter
// - Trigger clear never sets the overflow flag
// - Count write in the same cycle as a trigger wins
// - Count bytes are left unchanged by every reset
// - Power-on reset clears control to zero; stopped, 1:1 prescale
// - Any write to a count byte clears the prescaler
module timer_counter
   import timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TMR_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_pin,
   input wire logic osc_input_pin,
   input wire logic sleep_mode,
   input wire logic trig_a,
   input wire logic trig_b,
   output count_t count_value,
   output logic timebase_valid,
   output logic overflow_irq,
   output logic wake_request,
   output logic osc_enable,
   output logic osc_pins_input
);
   logic [`TMR_CTL_W-1:0] ctl_r;
   logic ovf_flag_r;
   logic ovf_flag_nxt;
   logic ovf_en_r;
   count_t count_r;
   count_t count_nxt;
   logic [`TMR_IDX_W-1:0] idx;
   logic aligned;
   logic hit_flags, hit_lo, hit_hi, hit_ctl, hit_en, hit_any;
   logic wr_fire;
   logic wr_lo, wr_hi, wr_cnt, wr_flags;
   logic [31:0] rd_mux;
   logic [1:0] pins_sync;
   logic ext_level;
   logic lvl_prev_r;
   logic armed_r;
   logic ext_rise;
   logic [`TMR_INSTR_CNT_W-1:0] instr_cnt_r;
   logic instr_en;
   logic run, src_ext, sync_n;
   logic src_pulse;
   logic presc_out;
   logic [`TMR_PRESC_W-1:0] presc_phase;
   logic sync_tick_r;
   logic inc;
   logic trig;
   logic ovf_set;
   logic [1:0] loaded_r;

   assign run = ctl_r[`TMR_CTL_RUN];
   assign src_ext = ctl_r[`TMR_CTL_SRC];
   assign sync_n = ctl_r[`TMR_CTL_SYNCN];
   assign trig = trig_a || trig_b;

   // Register decode
   assign idx = paddr[`TMR_PADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign hit_flags = aligned && (idx == `TMR_IDX_FLAGS);
   assign hit_lo = aligned && (idx == `TMR_IDX_CNT_LO);
   assign hit_hi = aligned && (idx == `TMR_IDX_CNT_HI);
   assign hit_ctl = aligned && (idx == `TMR_IDX_CTL);
   assign hit_en = aligned && (idx == `TMR_IDX_ENABLES);
   assign hit_any = hit_flags || hit_lo || hit_hi || hit_ctl || hit_en;

   // Writes land only on the completing access edge
   assign wr_fire = psel && penable && pready && pwrite && hit_any;
   assign wr_lo = wr_fire && hit_lo;
   assign wr_hi = wr_fire && hit_hi;
   assign wr_cnt = wr_lo || wr_hi;
   assign wr_flags = wr_fire && hit_flags;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_flags) begin
         rd_mux[`TMR_FLAG_OVF] = ovf_flag_r;
      end else if (hit_lo) begin
         rd_mux[7:0] = count_r[7:0];
      end else if (hit_hi) begin
         rd_mux[7:0] = count_r[15:8];
      end else if (hit_ctl) begin
         rd_mux[`TMR_CTL_W-1:0] = ctl_r;
      end else if (hit_en) begin
         rd_mux[`TMR_FLAG_OVF] = ovf_en_r;
      end
   end

   // One wait-free access phase: answer is prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // presetn stands for power-on and brown-out reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= `TMR_CTL_RST;
      end else if (wr_fire && hit_ctl) begin
         ctl_r <= pwdata[`TMR_CTL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_en_r <= `TMR_ENABLES_RST;
      end else if (wr_fire && hit_en) begin
         ovf_en_r <= pwdata[`TMR_FLAG_OVF];
      end
   end

   // A wrap in the clearing cycle still sets the flag
   always_comb begin
      ovf_flag_nxt = ovf_flag_r;
      if (wr_flags) begin
         ovf_flag_nxt = pwdata[`TMR_FLAG_OVF];
      end
      if (ovf_set) begin
         ovf_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag_r <= `TMR_FLAGS_RST;
      end else begin
         ovf_flag_r <= ovf_flag_nxt;
      end
   end

   // Instruction cycle enable from the core clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_cnt_r <= '0;
      end else if (instr_cnt_r == `TMR_INSTR_CNT_W'(`TMR_INSTR_DIV - 1)) begin
         instr_cnt_r <= '0;
      end else begin
         instr_cnt_r <= instr_cnt_r + `TMR_INSTR_CNT_W'(1);
      end
   end
   assign instr_en =
      (instr_cnt_r == `TMR_INSTR_CNT_W'(`TMR_INSTR_DIV - 1));

   pin_sync #(
      .W(2)
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({osc_input_pin, ext_count_pin}),
      .sync_out(pins_sync)
   );

   // Pin choice follows the oscillator enable
   assign ext_level = pins_sync[ctl_r[`TMR_CTL_OSC]];

   // Arming needs a low level first, so a pin already high is not counted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_prev_r <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         lvl_prev_r <= ext_level;
         if (!(run && src_ext)) begin
            armed_r <= 1'b0;
         end else if (!ext_level) begin
            armed_r <= 1'b1;
         end
      end
   end
   assign ext_rise = ext_level && !lvl_prev_r && armed_r;

   // Instruction clock halts in sleep; external edges keep feeding prescaler
   assign src_pulse = run && (src_ext ? ext_rise
                                      : (instr_en && !sleep_mode));

   edge_prescaler u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .src_pulse(src_pulse),
      .clear(wr_cnt),
      .ratio(prescale_e'(ctl_r[`TMR_CTL_PS_HI:`TMR_CTL_PS_LO])),
      .out_pulse(presc_out),
      .phase(presc_phase)
   );

   // Synchroniser stage after the prescaler, shut off in sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_tick_r <= 1'b0;
      end else begin
         sync_tick_r <= presc_out && !sleep_mode;
      end
   end

   always_comb begin
      if (!src_ext) begin
         inc = presc_out;
      end else if (sync_n) begin
         inc = presc_out;
      end else begin
         inc = sync_tick_r && run;
      end
   end

   assign ovf_set = inc && !wr_cnt && !trig && (count_r == 16'hFFFF);

   always_comb begin
      count_nxt = count_r;
      if (wr_lo) begin
         count_nxt = {count_r[15:8], pwdata[7:0]};
      end else if (wr_hi) begin
         count_nxt = {pwdata[7:0], count_r[7:0]};
      end else if (trig) begin
         count_nxt = 16'h0000;
      end else if (inc) begin
         count_nxt = count_r + 16'h0001;
      end
   end

   // No reset here: the count survives every reset
   always_ff @(posedge pclk) begin
      count_r <= count_nxt;
   end

   always_ff @(posedge pclk) begin
      count_value <= count_nxt;
   end

   // Compare units should not trust the count in asynchronous mode;
   // the count has no reset, so the stopped check waits until both bytes are loaded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timebase_valid <= 1'b1;
         loaded_r <= 2'b00;
      end else begin
         timebase_valid <= !(src_ext && sync_n);
         loaded_r <= loaded_r | {wr_hi || trig, wr_lo || trig};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_irq <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         overflow_irq <= ovf_flag_r && ovf_en_r;
         wake_request <= sleep_mode && ovf_flag_r && ovf_en_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_enable <= 1'b0;
         osc_pins_input <= 1'b0;
      end else begin
         osc_enable <= ctl_r[`TMR_CTL_OSC];
         osc_pins_input <= ctl_r[`TMR_CTL_OSC];
      end
   end

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      ovf_set |=> (count_r == 16'h0000) && ovf_flag_r;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap lost");

   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn)
      ##1 overflow_irq == $past(ovf_flag_r && ovf_en_r);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq not gated by enable");

   property p_stopped;
      @(posedge pclk) disable iff (!presetn)
      (!run && !wr_cnt && !trig && loaded_r == 2'b11)
         |=> (count_r == $past(count_r));
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("count moved while stopped");

   property p_internal_step;
      @(posedge pclk) disable iff (!presetn)
      (run && !src_ext && ctl_r[5:4] == 2'b00 && instr_en && !sleep_mode
         && !wr_cnt && !trig) |=> (count_r == $past(count_r) + 16'h0001);
   endproperty
   a_internal_step: assert property (p_internal_step)
      else $error("internal tick missed");

   property p_trig_clear;
      @(posedge pclk) disable iff (!presetn)
      (trig && !wr_cnt && !wr_flags && !ovf_flag_r)
         |=> (count_r == 16'h0000) && !ovf_flag_r;
   endproperty
   a_trig_clear: assert property (p_trig_clear)
      else $error("trigger clear wrong");

   property p_write_wins;
      @(posedge pclk) disable iff (!presetn)
      (wr_lo && trig) |=> (count_r[7:0] == $past(pwdata[7:0]));
   endproperty
   a_write_wins: assert property (p_write_wins)
      else $error("trigger beat write");

   property p_presc_clear;
      @(posedge pclk) disable iff (!presetn)
      wr_cnt |=> (presc_phase == 3'h0);
   endproperty
   a_presc_clear: assert property (p_presc_clear)
      else $error("prescaler not cleared");

   property p_sync_sleep;
      @(posedge pclk) disable iff (!presetn)
      (sleep_mode && src_ext && !sync_n && !wr_cnt && !trig)[*2]
         |=> (count_r == $past(count_r));
   endproperty
   a_sync_sleep: assert property (p_sync_sleep)
      else $error("synced count moved in sleep");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      (sleep_mode && ovf_flag_r && ovf_en_r) |=> wake_request;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");

   property p_ctl_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_ctl)
         |=> pready && prdata == {26'h0, $past(ctl_r)};
   endproperty
   a_ctl_read: assert property (p_ctl_read)
      else $error("control read wrong");

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      (ovf_flag_r && !wr_flags) |=> ovf_flag_r;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped");
endmodule // timer_counter
`default_nettype wire

// [logic/timer_defs.svh]
// Register indices, field positions, reset values and timing counts
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define TMR_PADDR_W 12
`define TMR_IDX_W 10
`define TMR_IDX_FLAGS 10'h00C
`define TMR_IDX_CNT_LO 10'h00E
`define TMR_IDX_CNT_HI 10'h00F
`define TMR_IDX_CTL 10'h010
`define TMR_IDX_ENABLES 10'h08C

`define TMR_CTL_W 6
`define TMR_CTL_RUN 0
`define TMR_CTL_SRC 1
`define TMR_CTL_SYNCN 2
`define TMR_CTL_OSC 3
`define TMR_CTL_PS_LO 4
`define TMR_CTL_PS_HI 5
`define TMR_CTL_RST 6'h00
`define TMR_FLAG_OVF 0
`define TMR_FLAGS_RST 1'b0
`define TMR_ENABLES_RST 1'b0

`define TMR_CLK_PERIOD_NS 100
`define TMR_INSTR_PERIOD_NS 400
`define TMR_INSTR_DIV ((`TMR_INSTR_PERIOD_NS) / (`TMR_CLK_PERIOD_NS))
`define TMR_INSTR_CNT_W 2
`define TMR_PRESC_W 3

`endif

// [logic/timer_pkg.sv]
// Types shared by the timer counter design
`default_nettype none
package timer_pkg;
   typedef enum logic [1:0] {
      PS_DIV1 = 2'b00,
      PS_DIV2 = 2'b01,
      PS_DIV4 = 2'b10,
      PS_DIV8 = 2'b11
   } prescale_e;
   typedef logic [15:0] count_t;
endpackage
`default_nettype wire

// [sim/ext_clk_src.sv]
// Behavioural external clock source for the timer count pins
`timescale 1ns/1ps
`default_nettype none
module ext_clk_src (
   output logic ext_count_pin,
   output logic osc_input_pin
);
   // Both pins rest low between bursts and start low
   initial begin
      ext_count_pin = 1'b0;
      osc_input_pin = 1'b0;
   end
   // Slow edges, unrelated in phase to pclk; the pin is still outside bursts
   task automatic burst(input bit on_osc, input int n, input int half_ns);
      for (int i = 0; i < n; i++) begin
         #(half_ns);
         if (on_osc) osc_input_pin = 1'b1;
         else ext_count_pin = 1'b1;
         #(half_ns);
         if (on_osc) osc_input_pin = 1'b0;
         else ext_count_pin = 1'b0;
      end
   endtask
endmodule // ext_clk_src
`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench for the sixteen-bit timer counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module tb;
   import timer_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, sleep_mode, trig_a, trig_b;
   logic [`TMR_PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, timebase_valid, overflow_irq, wake_request;
   logic osc_enable, osc_pins_input, ext_count_pin, osc_input_pin;
   count_t count_value;
   int miscompares = 0;
   int n_tests = 0;
   localparam logic [11:0] A_FLG = {`TMR_IDX_FLAGS, 2'b00};
   localparam logic [11:0] A_LO = {`TMR_IDX_CNT_LO, 2'b00};
   localparam logic [11:0] A_HI = {`TMR_IDX_CNT_HI, 2'b00};
   localparam logic [11:0] A_CTL = {`TMR_IDX_CTL, 2'b00};
   localparam logic [11:0] A_EN = {`TMR_IDX_ENABLES, 2'b00};

   timer_counter timer_counter_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_count_pin(ext_count_pin), .osc_input_pin(osc_input_pin),
      .sleep_mode(sleep_mode), .trig_a(trig_a), .trig_b(trig_b),
      .count_value(count_value), .timebase_valid(timebase_valid),
      .overflow_irq(overflow_irq), .wake_request(wake_request),
      .osc_enable(osc_enable), .osc_pins_input(osc_pins_input));
   ext_clk_src ext_clk_src_i (.ext_count_pin(ext_count_pin),
      .osc_input_pin(osc_input_pin));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Cycles until count_value next moves, capped so a stuck counter ends
   task automatic gap(output int n);
      count_t c;
      c = count_value;
      n = 0;
      while (count_value === c && n < 200) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic set_count(input logic [15:0] v);
      wr(A_CTL, 32'h0000_0000); // Stopped before writing
      wr(A_LO, {24'h0, v[7:0]});
      wr(A_HI, {24'h0, v[15:8]});
   endtask

   task automatic t_regs();
      logic [31:0] r;
      logic e;
      rd(A_CTL, r);
      chk("ctl reset", r, 32'h0000_0000);
      rd(A_FLG, r);
      chk("flags reset", r, 32'h0000_0000);
      wr(A_CTL, 32'h0000_00F0);
      rd(A_CTL, r);
      chk("ctl unused bits", r, 32'h0000_0030);
      apb(1'b0, 12'h004, 32'h0, r, e);
      chk("unmapped err", {31'h0, e}, 32'h0000_0001);
      set_count(16'h1234);
      rd(A_HI, r);
      chk("count high", r, 32'h0000_0012);
   endtask

   task automatic t_rates();
      logic [31:0] ctl [5] = '{32'h01, 32'h11, 32'h21, 32'h31, 32'h05};
      int expv [5] = '{4, 8, 16, 32, 4};
      int n;
      for (int i = 0; i < 5; i++) begin
         wr(A_CTL, ctl[i]);
         gap(n);
         gap(n);
         gap(n);
         chk("tick gap", n, expv[i]);
      end
   endtask

   task automatic t_overflow();
      logic [31:0] r;
      int n;
      set_count(16'hFFFE);
      wr(A_EN, 32'h0000_0001);
      wr(A_CTL, 32'h0000_0001);
      gap(n);
      gap(n);
      chk("wrap", count_value, 16'h0000);
      cycles(3);
      rd(A_FLG, r);
      chk("flag set", r, 32'h0000_0001);
      chk("irq", overflow_irq, 1'b1);
      wr(A_EN, 32'h0000_0000);
      cycles(2);
      chk("irq masked", overflow_irq, 1'b0);
      rd(A_FLG, r);
      chk("flag sticky", r, 32'h0000_0001);
      wr(A_FLG, 32'h0000_0000);
      rd(A_FLG, r);
      chk("flag cleared", r, 32'h0000_0000);
   endtask

   task automatic t_trigger();
      logic [31:0] r;
      for (int t = 0; t < 2; t++) begin
         set_count(16'h1255);
         wr(A_CTL, 32'h0000_0001);
         trig_a <= (t == 0);
         trig_b <= (t == 1);
         @(posedge pclk);
         trig_a <= 1'b0;
         trig_b <= 1'b0;
         cycles(2);
         chk("trig clear", count_value < 16'h0003, 1'b1);
         rd(A_FLG, r);
         chk("trig no flag", r, 32'h0000_0000);
      end
      // Trigger raised so that it stands at the write's access edge
      set_count(16'h1255);
      fork
         wr(A_LO, 32'h0000_0077);
         begin
            repeat (2) @(posedge pclk);
            trig_a <= 1'b1;
            @(posedge pclk);
            trig_a <= 1'b0;
         end
      join
      rd(A_LO, r);
      chk("write beats trig lo", r, 32'h0000_0077);
      chk("write beats trig", count_value, 16'h1277);
   endtask

   task automatic t_reset();
      logic [31:0] r;
      set_count(16'hA5C3);
      wr(A_CTL, 32'h0000_0030);
      @(posedge pclk);
      presetn <= 1'b0;
      cycles(2);
      presetn <= 1'b1;
      cycles(2);
      rd(A_CTL, r);
      chk("ctl after reset", r, 32'h0000_0000);
      chk("count kept", count_value, 16'hA5C3);
   endtask

   task automatic t_external();
      set_count(16'h0000);
      wr(A_CTL, 32'h0000_0003);
      ext_clk_src_i.burst(1'b0, 5, 730);
      cycles(8);
      chk("pin count", count_value, 16'h0005);
      wr(A_CTL, 32'h0000_000B);
      cycles(2);
      chk("osc pins in", osc_pins_input, 1'b1);
      chk("osc enable", osc_enable, 1'b1);
      ext_clk_src_i.burst(1'b0, 2, 730);
      ext_clk_src_i.burst(1'b1, 3, 730);
      cycles(8);
      chk("osc count", count_value, 16'h0008);
      sleep_mode <= 1'b1;
      wr(A_CTL, 32'h0000_0003);
      ext_clk_src_i.burst(1'b0, 4, 730);
      cycles(8);
      chk("sync sleep", count_value, 16'h0008);
      wr(A_CTL, 32'h0000_0007);
      ext_clk_src_i.burst(1'b0, 4, 730);
      cycles(8);
      chk("async sleep", count_value, 16'h000C);
      chk("timebase", timebase_valid, 1'b0);
      set_count(16'hFFFF);
      wr(A_EN, 32'h0000_0001);
      wr(A_CTL, 32'h0000_0007);
      ext_clk_src_i.burst(1'b0, 1, 730);
      cycles(8);
      chk("wake", wake_request, 1'b1);
      sleep_mode <= 1'b0;
   endtask

   task automatic conclude();
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      sleep_mode = 1'b0;
      trig_a = 1'b0;
      trig_b = 1'b0;
      cycles(6);
      presetn <= 1'b1;
      t_regs();
      t_rates();
      t_overflow();
      t_trigger();
      t_reset();
      t_external();
      conclude();
   end

   // The whole run needs well under 3000 cycles
   initial begin
      #(100 * 30000);
      miscompares++;
      conclude();
   end
endmodule // tb
`default_nettype wire
